// >>> rtl/bas_pkg.sv
`default_nettype none
package bas_pkg;
  // ****************************************
  // link and command/address layout
  // ****************************************
  localparam int DQ_W           = 16;
  localparam int CA_W           = 48;
  localparam int CA_BEATS       = 3;
  localparam int BURST_TYPE_BIT = 45;
  localparam int ADDR_HI_MSB    = 44;
  localparam int ADDR_HI_LSB    = 16;
  localparam int ADDR_LO_MSB    = 2;
  localparam int ADDR_W         = (ADDR_HI_MSB - ADDR_HI_LSB + 1) + (ADDR_LO_MSB + 1);
  localparam int SYNC_W         = DQ_W + 2;
  // synchroniser reset: chip select seen high, link clock low
  localparam logic [SYNC_W-1:0] SYNC_RST = 18'h2_0000;

  // ****************************************
  // config_word_zero fields and reset values
  // ****************************************
  localparam int         CFG_HYBRID_BIT = 2;
  localparam int         CFG_BL_MSB     = 1;
  localparam logic       CFG_HYBRID_RST = 1'b1;
  localparam logic [1:0] CFG_BL_RST     = 2'b11;

  // burst length codes and their step counts (one step is two words)
  localparam logic [1:0] BL_128    = 2'b00;
  localparam logic [1:0] BL_64     = 2'b01;
  localparam logic [1:0] BL_16     = 2'b10;
  localparam logic [1:0] BL_32     = 2'b11;
  localparam logic [6:0] STEPS_128 = 7'h40;
  localparam logic [6:0] STEPS_64  = 7'h20;
  localparam logic [6:0] STEPS_16  = 7'h08;
  localparam logic [6:0] STEPS_32  = 7'h10;

  // ****************************************
  // fifo defaults and sequencer states
  // ****************************************
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CA   = 2'b01,
    ST_DATA = 2'b10
  } bas_state_t;
endpackage
`default_nettype wire

// >>> rtl/bas_stream_if.sv
`default_nettype none
interface bas_stream_if #(parameter int WIDTH = 32) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/bas_fifo.sv
`default_nettype none
module bas_fifo
  import bas_pkg::*;
#(
  parameter int WIDTH = ADDR_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic    clk_sys,
  input wire logic    rst_n,
  // fill and drain sides
  bas_stream_if.snk   wr,
  bas_stream_if.src   rd
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  // ****************************************
  // parameter check
  // ****************************************
  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad
      $error("bas_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [PTR_W:0]   count;
  logic             do_wr;
  logic             do_rd;

  assign wr.ready = (count != FULL_CNT);
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rptr];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  // storage has no reset; rd.data shows mem[rptr] even while rd.valid is low
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wptr] <= wr.data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= rptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

  chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count <= FULL_CNT) else $error("fifo count beyond depth");
  chk_fifo_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    do_wr && !do_rd |=> count == $past(count) + 1'b1) else $error("fifo count missed a write");
  cov_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_n) !wr.ready);
endmodule
`default_nettype wire

// >>> rtl/bas_burst_seq.sv
`default_nettype none
module bas_burst_seq
  import bas_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // link pins from the memory controller
  input  wire logic              link_ck,
  input  wire logic              cs_n,
  input  wire logic [DQ_W-1:0]   dq,
  // configuration load, same clock domain
  input  wire logic              cfg_load,
  input  wire logic [DQ_W-1:0]   config_word_zero,
  // address stream out
  output logic                   addr_valid,
  input  wire logic              addr_ready,
  output logic [ADDR_W-1:0]      addr_word,
  // status
  output logic                   burst_active,
  output logic                   wrap_active,
  output logic                   overrun,
  output logic                   hybrid_wrap_select,
  output logic [1:0]             burst_len_code
);

  // ****************************************
  // parameter check
  // ****************************************
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bas_burst_seq: buffer depth must be a power of two of at least 2");
    end
  endgenerate

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] pin_s1;
  logic [SYNC_W-1:0] pin_s2;
  logic              ck_prev;
  logic              ck_s;
  logic              cs_active;
  logic [DQ_W-1:0]   dq_s;
  logic              ck_rise;
  logic              ck_edge;

  // idle pins after reset, so no false edge or select follows release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= SYNC_RST;
      pin_s2 <= SYNC_RST;
    end else begin
      pin_s1 <= {cs_n, link_ck, dq};
      pin_s2 <= pin_s1;
    end
  end

  assign ck_s      = pin_s2[DQ_W];
  assign cs_active = !pin_s2[DQ_W+1];
  assign dq_s      = pin_s2[DQ_W-1:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev <= 1'b0;
    end else begin
      ck_prev <= ck_s;
    end
  end

  // ddr link: command beats land on both edges, steps on rising edges
  assign ck_rise = ck_s && !ck_prev;
  assign ck_edge = ck_s != ck_prev;

  // ****************************************
  // configuration word
  // ****************************************
  logic       cfg_touched;
  bas_state_t state;

  // only taken between bursts so a running burst keeps its shape
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hybrid_wrap_select <= CFG_HYBRID_RST;
      burst_len_code     <= CFG_BL_RST;
      cfg_touched        <= 1'b0;
    end else if (cfg_load && state == ST_IDLE) begin
      hybrid_wrap_select <= config_word_zero[CFG_HYBRID_BIT];
      burst_len_code     <= config_word_zero[CFG_BL_MSB:0];
      cfg_touched        <= 1'b1;
    end
  end

  logic [6:0] sel_steps;

  always_comb begin
    case (burst_len_code)
      BL_128:  sel_steps = STEPS_128;
      BL_64:   sel_steps = STEPS_64;
      BL_16:   sel_steps = STEPS_16;
      default: sel_steps = STEPS_32;
    endcase
  end

  // ****************************************
  // transaction state
  // ****************************************
  logic [1:0]          beat;
  logic [CA_W-DQ_W-1:0] ca_sh;
  logic [CA_W-1:0]     ca_full;
  logic                load;
  logic [ADDR_W-1:0]   start_addr;
  logic                start_wrap;

  // three beats, the first one in the top bits
  assign ca_full    = {ca_sh, dq_s};
  assign load       = state == ST_CA && ck_edge && beat == 2'(CA_BEATS - 1);
  assign start_addr = {ca_full[ADDR_HI_MSB:ADDR_HI_LSB], ca_full[ADDR_LO_MSB:0]};
  assign start_wrap = !ca_full[BURST_TYPE_BIT];

  // the controller alone ends a burst by raising chip select
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!cs_active) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_CA;
        ST_CA: begin
          if (load) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: state <= ST_DATA;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      beat  <= 2'h0;
      ca_sh <= '0;
    end else if (state != ST_CA) begin
      beat <= 2'h0;
    end else if (ck_edge) begin
      beat  <= beat + 2'h1;
      ca_sh <= {ca_sh[CA_W-2*DQ_W-1:0], dq_s};
    end
  end

  // ****************************************
  // address sequencer
  // ****************************************
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] grp_base;
  logic [ADDR_W-1:0] grp_mask;
  logic [ADDR_W-1:0] sel_mask;
  logic [6:0]        grp_steps;
  logic [6:0]        step_cnt;
  logic              wrap_phase;
  logic              hyb;
  logic              push;
  logic              adv;
  logic              wrap_done;

  bas_stream_if #(.WIDTH(ADDR_W)) fill_if ();
  bas_stream_if #(.WIDTH(ADDR_W)) drain_if ();

  assign sel_mask  = ADDR_W'(sel_steps - 7'h01);
  assign grp_mask  = ADDR_W'(grp_steps - 7'h01);
  assign push      = state == ST_DATA && cs_active && ck_rise;
  assign adv       = push && fill_if.ready;
  assign wrap_done = hyb && step_cnt == grp_steps - 7'h01;

  // wrap_phase is only reloaded by a command, so it lingers between bursts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr       <= '0;
      grp_base   <= '0;
      grp_steps  <= STEPS_32;
      step_cnt   <= 7'h00;
      wrap_phase <= 1'b0;
      hyb        <= 1'b0;
    end else if (load) begin
      addr       <= start_addr;
      grp_base   <= start_addr & ~sel_mask;
      grp_steps  <= sel_steps;
      step_cnt   <= 7'h00;
      wrap_phase <= start_wrap;
      hyb        <= start_wrap && !hybrid_wrap_select;
    end else if (adv) begin
      if (!wrap_phase) begin
        addr <= addr + 1'b1;
      end else if (wrap_done) begin
        addr       <= grp_base + ADDR_W'(grp_steps);
        wrap_phase <= 1'b0;
      end else begin
        // upper bits held, low bits roll over inside the group
        addr     <= (addr & ~grp_mask) | ((addr + 1'b1) & grp_mask);
        step_cnt <= step_cnt + 7'h01;
      end
    end
  end

  // a full fifo cannot hold the link off, so a lost step is flagged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (push && !fill_if.ready) begin
      overrun <= 1'b1;
    end else if (load) begin
      overrun <= 1'b0;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  assign fill_if.valid  = push;
  assign fill_if.data   = addr;
  assign drain_if.ready = addr_ready;
  assign addr_valid     = drain_if.valid;
  assign addr_word      = drain_if.data;
  assign burst_active   = state == ST_DATA;
  assign wrap_active    = wrap_phase;

  // the link cannot be paused, so the buffer rides out consumer stalls
  bas_fifo #(
    .WIDTH (ADDR_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (fill_if),
    .rd      (drain_if)
  );

  // ****************************************
  // checks
  // ****************************************
  chk_group_bounds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv && wrap_phase && !wrap_done |=> (addr & ~grp_mask) == grp_base)
    else $error("wrap left its group");
  chk_start_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load |=> addr == $past(start_addr) && step_cnt == 7'h00)
    else $error("burst did not start at command address");
  chk_wrap_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv && wrap_phase && !wrap_done && (addr & grp_mask) == grp_mask |=> (addr & grp_mask) == '0)
    else $error("wrap did not return to group bottom");
  chk_hybrid_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv && wrap_phase && wrap_done |=> !wrap_phase && addr == grp_base + ADDR_W'(grp_steps))
    else $error("hybrid burst missed next group");
  chk_linear_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv && !wrap_phase && state == ST_DATA |=> addr == $past(addr) + 1'b1)
    else $error("linear address did not increment");
  chk_cs_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cs_active |=> state == ST_IDLE ##1 !push)
    else $error("burst continued after chip select rose");
  chk_burst_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_DATA && cs_active |=> state == ST_DATA)
    else $error("burst ended while chip select low");
  chk_mode_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load |=> hyb == ($past(start_wrap) && !$past(hybrid_wrap_select)))
    else $error("wrap style chosen wrongly");
  chk_cfg_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state != ST_IDLE |=> $stable(hybrid_wrap_select) && $stable(burst_len_code))
    else $error("configuration changed during a burst");
  chk_cfg_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_touched |-> hybrid_wrap_select && burst_len_code == CFG_BL_RST)
    else $error("configuration left its reset value");
  chk_step_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load && burst_len_code == BL_16 |=> grp_steps == STEPS_16 && grp_mask == 32'h0000_0007)
    else $error("16 word group not 8 steps");
  chk_linear_type: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load && !start_wrap |=> !wrap_phase && !hyb)
    else $error("linear burst entered wrap phase");
  chk_legacy_loop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv && wrap_phase && !hyb |=> wrap_phase && (addr & ~grp_mask) == ($past(addr) & ~grp_mask))
    else $error("legacy wrap carried upward");

  cov_hybrid_exit: cover property (@(posedge clk_sys) disable iff (!rst_n) adv && wrap_phase && wrap_done);
  cov_legacy_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n)
    adv && wrap_phase && !hyb && (addr & grp_mask) == grp_mask);
  cov_linear: cover property (@(posedge clk_sys) disable iff (!rst_n) load && !start_wrap);
  cov_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n) push && !fill_if.ready);
endmodule
`default_nettype wire

// >>> dv/bas_host_model.sv
`default_nettype none
module bas_host_model
  import bas_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // link pins
  output logic             link_ck,
  output logic             cs_n,
  output logic [DQ_W-1:0]  dq
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    link_ck = 1'b0;
    cs_n    = 1'b1;
    dq      = 16'h0000;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one link edge, beat held across both sync stages
  task automatic toggle(input logic [DQ_W-1:0] beat);
    dq = beat;
    wait_clk(2);
    link_ck = ~link_ck;
    wait_clk(2);
    dq = ~beat;
  endtask

  // n pushes; link clock parked low outside frames
  task automatic burst(input logic [CA_W-1:0] ca, input int n);
    cs_n = 1'b0;
    wait_clk(4);
    toggle(ca[47:32]);
    toggle(ca[31:16]);
    toggle(ca[15:0]);
    for (int i = 0; i < 2 * n + 1; i++) begin
      toggle(dq ^ 16'h5a5a);
    end
    wait_clk(4);
    cs_n = 1'b1;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// >>> dv/bas_burst_seq_tb.sv
`default_nettype none
`define CHK(what, exp, act) \
  begin \
    n_tests++; \
    if ((act) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, act); \
    end \
  end
module bas_burst_seq_tb;
  import bas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic              clk_sys, rst_n, link_ck, cs_n, cfg_load;
  logic [DQ_W-1:0]   dq, config_word_zero;
  logic              addr_valid, addr_ready, burst_active, wrap_active, overrun;
  logic              hybrid_wrap_select, drain_en;
  logic [1:0]        burst_len_code;
  logic [ADDR_W-1:0] addr_word;
  logic [ADDR_W-1:0] got[$];
  int                n_errors, n_tests, seed;

  bas_host_model u_host (.clk_sys(clk_sys), .link_ck(link_ck), .cs_n(cs_n), .dq(dq));
  bas_burst_seq #(.DEPTH(16)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .link_ck(link_ck), .cs_n(cs_n), .dq(dq),
    .cfg_load(cfg_load), .config_word_zero(config_word_zero), .addr_valid(addr_valid),
    .addr_ready(addr_ready), .addr_word(addr_word), .burst_active(burst_active),
    .wrap_active(wrap_active), .overrun(overrun), .hybrid_wrap_select(hybrid_wrap_select),
    .burst_len_code(burst_len_code));

  always #25 clk_sys = ~clk_sys;
  // random stalls keep the fifo partly filled
  always @(negedge clk_sys) addr_ready <= drain_en && 1'($urandom);
  always @(posedge clk_sys) if (addr_valid === 1'b1 && addr_ready === 1'b1) got.push_back(addr_word);

  // ****************************************
  // expectations
  // ****************************************
  function automatic int steps_of(input logic [1:0] code);
    case (code)
      2'b00: return 64;
      2'b01: return 32;
      2'b10: return 8;
      default: return 16;
    endcase
  endfunction

  // mode 0 legacy, 1 hybrid, 2 linear
  function automatic logic [ADDR_W-1:0] exp_at(input logic [ADDR_W-1:0] s, input int g, input int mode, input int i);
    logic [ADDR_W-1:0] base;
    base = s & ~(ADDR_W'(g) - 1);
    if (mode == 2) return s + ADDR_W'(i);
    if (mode == 1 && i >= g) return base + ADDR_W'(i);
    return base + ADDR_W'((int'(s - base) + i) % g);
  endfunction

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_reset;
    `CHK("hybrid_wrap_select", 1'b1, hybrid_wrap_select)
    `CHK("burst_len_code", 2'b11, burst_len_code)
    `CHK("addr_valid", 1'b0, addr_valid)
  endtask

  task automatic load_cfg(input logic hyb, input logic [1:0] code);
    config_word_zero = 16'($urandom);
    config_word_zero[CFG_HYBRID_BIT] = hyb;
    config_word_zero[CFG_BL_MSB:0] = code;
    cfg_load = 1'b1;
    @(negedge clk_sys);
    cfg_load = 1'b0;
    @(negedge clk_sys);
    `CHK("hybrid_wrap_select", hyb, hybrid_wrap_select)
    `CHK("burst_len_code", code, burst_len_code)
  endtask

  task automatic run(input logic hyb, input logic [1:0] code, input logic lin, input logic [ADDR_W-1:0] s,
                     input int n, input logic stall);
    logic [CA_W-1:0] ca;
    int              mode;
    int              want;
    mode = lin ? 2 : (hyb ? 0 : 1);
    want = stall && n > 16 ? 16 : n;
    ca = '0;
    ca[BURST_TYPE_BIT] = lin;
    ca[ADDR_HI_MSB:ADDR_HI_LSB] = s[ADDR_W-1:ADDR_LO_MSB+1];
    ca[ADDR_LO_MSB:0] = s[ADDR_LO_MSB:0];
    load_cfg(hyb, code);
    got.delete();
    drain_en = !stall;
    // a config load in mid-burst must not bend the running burst
    fork
      u_host.burst(ca, n);
      begin
        repeat (30) @(negedge clk_sys);
        config_word_zero = ~config_word_zero;
        cfg_load = 1'b1;
        @(negedge clk_sys);
        cfg_load = 1'b0;
      end
    join
    `CHK("burst_active", 1'b0, burst_active)
    `CHK("overrun", stall && n > 16, overrun)
    `CHK("wrap_active", !lin && (hyb || want < steps_of(code)), wrap_active)
    `CHK("hybrid_wrap_select", hyb, hybrid_wrap_select)
    `CHK("burst_len_code", code, burst_len_code)
    drain_en = 1'b1;
    for (int k = 0; k < 400 && got.size() < want; k++) @(negedge clk_sys);
    repeat (8) @(negedge clk_sys);
    `CHK("count", want, got.size())
    for (int i = 0; i < want && i < got.size(); i++) begin
      `CHK("addr", exp_at(s, steps_of(code), mode, i), got[i])
    end
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    cfg_load = 1'b0;
    config_word_zero = 16'h0000;
    addr_ready = 1'b0;
    drain_en = 1'b1;
    n_errors = 0;
    n_tests = 0;
    seed = $urandom(72655);
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk_reset();
    run(1, BL_16, 0, 32'h0000_000c, 12, 0);
    run(0, BL_16, 0, 32'h0000_000c, 20, 0);
    run(0, BL_16, 0, 32'h0000_0002, 11, 0);
    run(0, BL_32, 0, 32'h0000_000a, 24, 0);
    run(0, BL_64, 0, 32'h0000_002e, 40, 0);
    run(0, BL_128, 0, 32'h0000_0003, 70, 0);
    run(1, BL_64, 0, 32'h1234_5603, 34, 0);
    run(0, BL_16, 1, 32'h0000_0003, 10, 0);
    run(1, BL_128, 1, 32'h00ff_fffe, 6, 0);
    // fifo full: later pushes dropped, sticky flag
    run(1, BL_32, 0, 32'h0000_0005, 20, 1);
    run(0, BL_16, 0, 32'h0000_0007, 9, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk_reset();
    repeat (20) run(1'($urandom), 2'($urandom), 1'($urandom), ADDR_W'($urandom), 1 + $urandom % 30, 0);
    wrap_up();
  end

  // longest legal run is well under a millisecond
  initial begin
    #2_000_000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
